// [include/ifs_pkg.sv]
/*
  Package for the interrupt and fail signalling block: register offsets,
  field positions, reset values, timing constants and shared types.
  Assumes a 50 MHz pclk and a 32-bit APB register bus.
*/
package ifs_pkg;

  // Byte addresses of the registers
  localparam logic [7:0] IFS_CTRL_OFS      = 8'h00;
  localparam logic [7:0] IFS_WAKE_A_OFS    = 8'h04;
  localparam logic [7:0] IFS_WAKE_B_OFS    = 8'h08;
  localparam logic [7:0] IFS_FAIL_STAT_OFS = 8'h0c;
  localparam logic [7:0] IFS_DEVICE_STATUS_OFS  = 8'h10;
  localparam logic [7:0] IFS_WAKE_LVL_OFS  = 8'h14;

  // Control register fields
  localparam int IFS_CTRL_INT_GLOBAL = 0;
  localparam int IFS_CTRL_FO_TEST    = 1;
  localparam int IFS_CTRL_OV_RST_EN  = 2;
  localparam int IFS_CTRL_PFS_LSB    = 4;
  localparam int IFS_CTRL_WEN_LSB    = 8;
  localparam logic [31:0] IFS_CTRL_MASK  = 32'h0000_0f77;
  localparam logic [31:0] IFS_CTRL_RESET = 32'h0000_0000;

  // Device status fields
  localparam int IFS_DEV_FAIL_FLAG = 0;
  localparam int IFS_DEV_WATCHDOG_FAIL_FLAG   = 1;
  localparam int IFS_DEV_HW_CFG    = 2;
  localparam int IFS_DEV_FO_LEVEL  = 3;

  // Highest pin function code that still selects the fail output
  localparam logic [2:0] IFS_PFS_FO_MAX = 3'h2;

  // Wake source bit positions in wake status a
  localparam int IFS_WK_CAN   = 0;
  localparam int IFS_WK_PIN   = 1;
  localparam int IFS_WK_TIMER = 2;

  // Timing, in microseconds, and the clock rate
  localparam int IFS_CLK_MHZ      = 50;
  localparam int IFS_T_PULSE_US   = 100;
  localparam int IFS_T_GAP_US     = 100;
  localparam int IFS_PULSE_CYCLES = IFS_T_PULSE_US * IFS_CLK_MHZ;
  localparam int IFS_GAP_CYCLES   = IFS_T_GAP_US * IFS_CLK_MHZ;

  // Consecutive watchdog failures needed before the fail output fires
  localparam logic [1:0] IFS_WD_LIMIT_LOW_CFG  = 2'h1;
  localparam logic [1:0] IFS_WD_LIMIT_HIGH_CFG = 2'h2;

  typedef enum logic [2:0]
  {
    IFS_MODE_INIT,
    IFS_MODE_NORMAL,
    IFS_MODE_STOP,
    IFS_MODE_SLEEP,
    IFS_MODE_RESTART,
    IFS_MODE_FAILSAFE
  } ifs_mode_type;

  typedef struct packed
  {
    logic wd_trigger_fail;
    logic wd_trigger_ok;
    logic wd_disabled;
    logic thermal_shutdown_level2;
    logic supply_short;
    logic supply_overvoltage;
  } ifs_fail_in_type;

  typedef struct packed
  {
    logic can;
    logic pin;
    logic timer;
    logic gpio;
  } ifs_wake_type;

endpackage

// [src/ifs_top.sv]
/*
  Interrupt pulse generator and fail output logic with APB registers.
  Assumes events arrive as one-cycle pulses synchronous to pclk, the mode
  comes from the device mode controller, and the bench resolves the
  interrupt and fail pins from the output enables.
*/
// Summary of operation
// RULE_01 - Interrupt pulls output low for nominal 100 us in Normal or Stop.
// RULE_02 - Output stays high at least 100 us between two pulses.
// RULE_03 - An interrupt pulse never changes the operating mode.
// RULE_04 - With global bit 0 only wake events raise interrupts.
// RULE_05 - A wake event interrupts only when its source is enabled.
// RULE_06 - With global bit 1 failure flags also raise interrupts.
// RULE_07 - Reset-forcing errors, power-on and device status never interrupt.
// RULE_08 - No pulse in Restart, Fail-Safe or Sleep mode.
// RULE_09 - Entering Stop with wake status still set raises an interrupt.
// RULE_10 - Status updates at pulse falling edge, held until cleared.
// RULE_11 - Host may re-read a status register after clearing it.
// RULE_12 - In Init the interrupt pin is sampled as configuration input.
// RULE_13 - Multipurpose pin defaults to open-drain active-low fail output.
// RULE_14 - Watchdog failure fires fail output: 2nd in cfg 3-4, 1st otherwise.
// RULE_15 - Thermal, supply short, and enabled overvoltage fire fail output.
// RULE_16 - Fail output sets fail flag and requests Fail-Safe for non-watchdog.
// RULE_17 - Activated fail output stays low in every mode until released.
// RULE_18 - Release in Normal needs no cause, flag cleared, watchdog fail gone.
// RULE_19 - Watchdog fail flag clears on Sleep, other Fail-Safe, Stop disable.
// RULE_20 - Test bit drives fail output; clearing it releases with no failure.
// RULE_21 - Test-only activation switches off on entering Restart.
// RULE_22 - Test bit always writable but only acts with fail function selected.
// RULE_23 - Pin function codes 000 to 010 select the fail output.
// RULE_24 - Pulse width and gap are counted in oscillator ticks.
// RULE_25 - Events during a pulse or gap merge into the next pulse.
`timescale 1ns/1ps
`default_nettype none
module ifs_top
  import ifs_pkg::*;
#(
  parameter int PULSE_CYCLES = IFS_PULSE_CYCLES,
  parameter int GAP_CYCLES   = IFS_GAP_CYCLES,
  parameter int FAIL_BITS    = 8
)
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 clk_en,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire ifs_mode_type         mode,
  input  wire logic [1:0]           dev_config,
  input  wire ifs_wake_type         wake_event,
  input  wire ifs_wake_type         wake_level,
  input  wire logic [FAIL_BITS-1:0] fail_event,
  input  wire ifs_fail_in_type      fail_in,
  input  wire logic                 intn_in,
  output logic                      intn_out,
  output logic                      intn_oe,
  input  wire logic                 fo_in,
  output logic                      fo_out,
  output logic                      fo_oe,
  output logic                      failsafe_request,
  output logic                      watchdog_fail_flag_request
);

  typedef enum logic [1:0]
  {
    IFS_ST_IDLE,
    IFS_ST_LOW,
    IFS_ST_GAP
  } ifs_state_type;

  localparam logic [15:0] PULSE_LAST = 16'(PULSE_CYCLES - 1);
  localparam logic [15:0] GAP_LAST   = 16'(GAP_CYCLES - 1);

  logic [31:0]          ctrl_reg;
  logic [2:0]           wake_a_reg;
  logic                 wake_b_reg;
  logic [FAIL_BITS-1:0] fail_stat_reg;
  logic [2:0]           pend_a_reg;
  logic                 pend_b_reg;
  logic [FAIL_BITS-1:0] pend_f_reg;
  logic                 stop_req_reg;
  ifs_state_type        state_reg;
  logic [15:0]          count_reg;
  logic                 intn_reg;
  logic                 hw_cfg_reg;
  logic                 fail_flag_reg;
  logic                 watchdog_fail_flag_reg;
  logic [1:0]           wd_count_reg;
  logic                 fail_active_reg;
  logic                 fo_drive_reg;
  logic                 failsafe_req_reg;
  logic                 wd_req_reg;
  ifs_mode_type         mode_prev_reg;
  logic [31:0]          prdata_reg;

  logic                 wr_access;
  logic                 rd_setup;
  logic                 addr_ok;
  logic                 int_mode;
  logic                 stop_entry;
  logic                 restart_entry;
  logic                 sleep_entry;
  logic                 failsafe_entry;
  logic [3:0]           wake_en;
  logic [2:0]           cause_a;
  logic                 cause_b;
  logic [FAIL_BITS-1:0] cause_f;
  logic                 irq_cause;
  logic                 pulse_start;
  logic                 merge;
  logic                 wd_fire;
  logic                 nonwd_cause;
  logic                 cond_present;
  logic                 fo_select;
  logic                 test_bit;
  logic [1:0]           wd_limit;

  function automatic logic ifs_w1c(input logic [7:0]  ofs,
                                   input logic [7:0]  addr,
                                   input logic        wr,
                                   input logic [31:0] data,
                                   input int          bitpos);
    return wr && (addr == ofs) && data[bitpos];
  endfunction

  function automatic logic ifs_decode(input logic [7:0] addr);
    return (addr == IFS_CTRL_OFS) || (addr == IFS_WAKE_A_OFS) ||
           (addr == IFS_WAKE_B_OFS) || (addr == IFS_FAIL_STAT_OFS) ||
           (addr == IFS_DEVICE_STATUS_OFS) || (addr == IFS_WAKE_LVL_OFS);
  endfunction

  // Zero-wait slave: read data is loaded at the setup edge
  assign wr_access = psel && penable && pwrite && addr_ok && clk_en;
  assign rd_setup  = psel && !penable && clk_en;
  assign addr_ok   = ifs_decode(paddr);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !addr_ok;
  assign prdata    = prdata_reg;

  assign int_mode       = (mode == IFS_MODE_NORMAL) ||
                          (mode == IFS_MODE_STOP); // RULE_08
  assign stop_entry     = (mode == IFS_MODE_STOP) &&
                          (mode_prev_reg != IFS_MODE_STOP);
  assign restart_entry  = (mode == IFS_MODE_RESTART) &&
                          (mode_prev_reg != IFS_MODE_RESTART);
  assign sleep_entry    = (mode == IFS_MODE_SLEEP) &&
                          (mode_prev_reg != IFS_MODE_SLEEP);
  assign failsafe_entry = (mode == IFS_MODE_FAILSAFE) &&
                          (mode_prev_reg != IFS_MODE_FAILSAFE);

  assign wake_en   = ctrl_reg[IFS_CTRL_WEN_LSB +: 4];
  assign cause_a   = pend_a_reg & wake_en[2:0]; // RULE_05
  assign cause_b   = pend_b_reg & wake_en[3]; // RULE_05
  // Only the general failure flags reach here; reset-forcing errors
  // and device status have no path into the pending set.
  assign cause_f   = ctrl_reg[IFS_CTRL_INT_GLOBAL] ?
                     pend_f_reg : '0; // RULE_04 RULE_06 RULE_07
  assign irq_cause = int_mode && ((|cause_a) || cause_b || (|cause_f));
  assign pulse_start = (state_reg == IFS_ST_IDLE) && int_mode &&
                       (irq_cause || stop_req_reg);
  // Non-interrupting events become visible at once; interrupting ones
  // wait for the falling edge of their pulse.
  assign merge = pulse_start || !irq_cause; // RULE_10

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_prev_reg <= IFS_MODE_INIT;
    else if (clk_en)
      mode_prev_reg <= mode;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= 32'h0000_0000;
    else if (rd_setup)
    begin
      case (paddr)
        IFS_CTRL_OFS:      prdata_reg <= ctrl_reg;
        IFS_WAKE_A_OFS:    prdata_reg <= {29'h0, wake_a_reg};
        IFS_WAKE_B_OFS:    prdata_reg <= {31'h0, wake_b_reg};
        IFS_FAIL_STAT_OFS: prdata_reg <= 32'(fail_stat_reg);
        IFS_DEVICE_STATUS_OFS:  prdata_reg <= {28'h0, fo_in, hw_cfg_reg,
                                          watchdog_fail_flag_reg, fail_flag_reg};
        IFS_WAKE_LVL_OFS:  prdata_reg <= {28'h0, wake_level};
        default:           prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Control register; the test bit stays writable in any pin function
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= IFS_CTRL_RESET;
    else if (clk_en)
    begin
      if (wr_access && (paddr == IFS_CTRL_OFS))
        ctrl_reg <= pwdata & IFS_CTRL_MASK; // RULE_22
      else if (restart_entry)
        ctrl_reg[IFS_CTRL_FO_TEST] <= 1'b0; // RULE_21
    end
  end

  // Pending events, merged into visible status; a set beats a clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_a_reg <= 3'h0;
      pend_b_reg <= 1'b0;
      pend_f_reg <= '0;
    end
    else if (clk_en)
    begin
      pend_a_reg <= (merge ? 3'h0 : pend_a_reg) |
                    {wake_event.timer, wake_event.pin,
                     wake_event.can}; // RULE_25
      pend_b_reg <= (merge ? 1'b0 : pend_b_reg) | wake_event.gpio;
      pend_f_reg <= (merge ? '0 : pend_f_reg) | fail_event; // RULE_25
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_a_reg    <= 3'h0;
      wake_b_reg    <= 1'b0;
      fail_stat_reg <= '0;
    end
    else if (clk_en)
    begin
      for (int i = 0; i < 3; i++)
        wake_a_reg[i] <= (wake_a_reg[i] &
                          !ifs_w1c(IFS_WAKE_A_OFS, paddr, wr_access,
                                   pwdata, i)) |
                         (merge & pend_a_reg[i]); // RULE_10
      wake_b_reg <= (wake_b_reg &
                     !ifs_w1c(IFS_WAKE_B_OFS, paddr, wr_access,
                              pwdata, 0)) |
                    (merge & pend_b_reg); // RULE_10
      for (int i = 0; i < FAIL_BITS; i++)
        fail_stat_reg[i] <= (fail_stat_reg[i] &
                             !ifs_w1c(IFS_FAIL_STAT_OFS, paddr, wr_access,
                                      pwdata, i)) |
                            (merge & pend_f_reg[i]); // RULE_10
    end
  end

  // Stop entry with leftover wake status asks for one pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stop_req_reg <= 1'b0;
    else if (clk_en)
    begin
      if (stop_entry && ((|wake_a_reg) || wake_b_reg))
        stop_req_reg <= 1'b1; // RULE_09
      else if (pulse_start || !int_mode)
        stop_req_reg <= 1'b0;
    end
  end

  // Pulse timer; it only drives the pin and never touches the mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= IFS_ST_IDLE;
      count_reg <= 16'h0000;
      intn_reg  <= 1'b1;
    end
    else if (clk_en)
    begin
      case (state_reg)
        IFS_ST_IDLE:
        begin
          if (pulse_start)
          begin
            state_reg <= IFS_ST_LOW; // RULE_03
            count_reg <= 16'h0000;
            intn_reg  <= 1'b0; // RULE_01
          end
        end
        IFS_ST_LOW:
        begin
          // Leaving the pulsing modes cuts the pulse short
          if ((count_reg == PULSE_LAST) || !int_mode)
          begin
            state_reg <= IFS_ST_GAP;
            count_reg <= 16'h0000;
            intn_reg  <= 1'b1; // RULE_01 RULE_08
          end
          else
            count_reg <= count_reg + 16'h0001; // RULE_24
        end
        IFS_ST_GAP:
        begin
          if (count_reg == GAP_LAST)
            state_reg <= IFS_ST_IDLE; // RULE_02
          else
            count_reg <= count_reg + 16'h0001; // RULE_24
        end
        default:
        begin
          state_reg <= IFS_ST_IDLE;
          count_reg <= 16'h0000;
          intn_reg  <= 1'b1;
        end
      endcase
    end
  end

  // In Init the pin is an input; its level picks the configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hw_cfg_reg <= 1'b0;
    else if (clk_en && (mode == IFS_MODE_INIT))
      hw_cfg_reg <= intn_in; // RULE_12
  end

  assign intn_out = intn_reg;
  assign intn_oe  = (mode != IFS_MODE_INIT); // RULE_12

  assign wd_limit     = dev_config[1] ? IFS_WD_LIMIT_HIGH_CFG :
                        IFS_WD_LIMIT_LOW_CFG; // RULE_14
  // Widened so a saturated count of 3 cannot wrap and hide a failure
  assign wd_fire      = fail_in.wd_trigger_fail &&
                        (({1'b0, wd_count_reg} + 3'h1) >=
                         {1'b0, wd_limit}); // RULE_14
  assign nonwd_cause  = fail_in.thermal_shutdown_level2 ||
                        fail_in.supply_short ||
                        (fail_in.supply_overvoltage &&
                         ctrl_reg[IFS_CTRL_OV_RST_EN]); // RULE_15
  assign cond_present = fail_in.thermal_shutdown_level2 ||
                        fail_in.supply_short ||
                        fail_in.supply_overvoltage; // RULE_18

  // Consecutive watchdog failure count, reset by a good trigger
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wd_count_reg <= 2'h0;
    else if (clk_en)
    begin
      if (fail_in.wd_trigger_ok)
        wd_count_reg <= 2'h0;
      else if (fail_in.wd_trigger_fail && (wd_count_reg != 2'h3))
        wd_count_reg <= wd_count_reg + 2'h1; // RULE_14
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      watchdog_fail_flag_reg <= 1'b0;
    else if (clk_en)
    begin
      if (wd_fire)
        watchdog_fail_flag_reg <= 1'b1;
      else if (fail_in.wd_trigger_ok || sleep_entry ||
               (failsafe_entry && nonwd_cause) ||
               ((mode == IFS_MODE_STOP) && fail_in.wd_disabled))
        watchdog_fail_flag_reg <= 1'b0; // RULE_18 RULE_19
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fail_flag_reg <= 1'b0;
    else if (clk_en)
    begin
      if (fo_select && (wd_fire || nonwd_cause))
        fail_flag_reg <= 1'b1; // RULE_16
      else if (ifs_w1c(IFS_DEVICE_STATUS_OFS, paddr, wr_access, pwdata,
                       IFS_DEV_FAIL_FLAG))
        fail_flag_reg <= 1'b0;
    end
  end

  // Latched failure; released only in Normal once everything is clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fail_active_reg <= 1'b0;
    else if (clk_en)
    begin
      if (fo_select && (wd_fire || nonwd_cause))
        fail_active_reg <= 1'b1; // RULE_14 RULE_15 RULE_17
      else if ((mode == IFS_MODE_NORMAL) && !cond_present &&
               !fail_flag_reg && !watchdog_fail_flag_reg)
        fail_active_reg <= 1'b0; // RULE_18
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      failsafe_req_reg <= 1'b0;
      wd_req_reg       <= 1'b0;
    end
    else if (clk_en)
    begin
      failsafe_req_reg <= fo_select && nonwd_cause; // RULE_16
      wd_req_reg       <= fo_select && wd_fire;
    end
  end

  assign failsafe_request = failsafe_req_reg;
  assign watchdog_fail_flag_request  = wd_req_reg;

  assign fo_select = (ctrl_reg[IFS_CTRL_PFS_LSB +: 3] <=
                      IFS_PFS_FO_MAX); // RULE_13 RULE_23
  assign test_bit  = ctrl_reg[IFS_CTRL_FO_TEST];

  // Open-drain pin: the output only ever pulls low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fo_drive_reg <= 1'b0;
    else if (clk_en)
      fo_drive_reg <= fo_select &&
                      (fail_active_reg || test_bit); // RULE_20 RULE_22
  end

  assign fo_out = 1'b0;
  assign fo_oe  = fo_drive_reg; // RULE_13 RULE_17

endmodule
`default_nettype wire

// [dv/ifs_asserts.sv]
/*
  Checker for the interrupt and fail signalling block.
  Assumes it is bound to ifs_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module ifs_asserts
  import ifs_pkg::*;
#(
  parameter int PULSE_CYCLES = IFS_PULSE_CYCLES,
  parameter int GAP_CYCLES   = IFS_GAP_CYCLES
)
(
  input wire logic            pclk,
  input wire logic            presetn,
  input wire ifs_mode_type    mode,
  input wire ifs_fail_in_type fail_in,
  input wire logic            intn_out,
  input wire logic            intn_oe,
  input wire logic            fo_out,
  input wire logic            fo_oe,
  input wire logic            failsafe_request,
  input wire logic            watchdog_fail_flag_request
);
  logic [15:0] low_cnt_reg;
  logic [15:0] high_cnt_reg;
  logic        mode_ok;

  assign mode_ok = (mode == IFS_MODE_NORMAL) || (mode == IFS_MODE_STOP);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Pulse and gap are far too long to unroll, so they are counted here
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_cnt_reg <= 16'h0000;
    else if (intn_out)
      low_cnt_reg <= 16'h0000;
    else
      low_cnt_reg <= low_cnt_reg + 16'h0001;
  end

  // Starts saturated so the first pulse after reset is not held back
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      high_cnt_reg <= 16'hffff;
    else if (!intn_out)
      high_cnt_reg <= 16'h0000;
    else if (high_cnt_reg != 16'hffff)
      high_cnt_reg <= high_cnt_reg + 16'h0001;
  end

  sequence s_pulse_end;
    $rose(intn_out) && mode_ok && $past(mode_ok);
  endsequence

  AST_PULSE_WIDTH: assert property (s_pulse_end |->
    low_cnt_reg == 16'(PULSE_CYCLES)) else $error("pulse width wrong");
  AST_PULSE_GAP: assert property ($fell(intn_out) |->
    high_cnt_reg >= 16'(GAP_CYCLES)) else $error("pulse gap too short");
  AST_MODE_GATE: assert property ($fell(intn_out) |->
    $past(mode_ok)) else $error("pulse outside normal or stop");
  AST_CFG_PIN: assert property (intn_oe ==
    (mode != IFS_MODE_INIT)) else $error("interrupt pin drive wrong");
  AST_OPEN_DRAIN: assert property (fo_oe |-> !fo_out)
    else $error("fail pin driven high");
  AST_FAIL_DRIVE: assert property ($rose(failsafe_request) |->
    ##[0:2] fo_oe) else $error("fail pin not driven");
  AST_FAIL_HOLD: assert property (fo_oe && failsafe_request |=>
    fo_oe) else $error("fail pin released with cause");
  AST_WD_CAUSE: assert property ($rose(watchdog_fail_flag_request) |->
    $past(fail_in.wd_trigger_fail) ##1 !watchdog_fail_flag_request)
    else $error("watchdog request without failure");

  cover property (s_pulse_end);
endmodule
`default_nettype wire

// [dv/ifs_host_model.sv]
/*
  Board and host side of the interrupt and fail pins.
  Assumes the bench supplies the configuration strap level.
*/
`timescale 1ns/1ps
`default_nettype none
module ifs_host_model
(
  input  wire logic intn_out,
  input  wire logic intn_oe,
  input  wire logic fo_out,
  input  wire logic fo_oe,
  input  wire logic strap,
  output logic      intn_pin,
  output logic      fo_pin
);
  // Strap resistor decides the level while the device does not drive
  assign intn_pin = intn_oe ? intn_out : strap;
  // Open-drain line with a board pull-up
  assign fo_pin = fo_oe ? fo_out : 1'b1;
endmodule
`default_nettype wire

// [dv/ifs_top_tb.sv]
/*
  Self-checking bench for the interrupt and fail signalling block.
  Assumes APB with zero wait states is still waited on through pready.
*/
`timescale 1ns/1ps
`default_nettype none
module ifs_top_tb;
  import ifs_pkg::*;
  localparam int PW = 20;
  localparam int GW = 15;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]      paddr, fail_event;
  logic [31:0]     pwdata, prdata, q;
  ifs_mode_type    mode;
  logic [1:0]      dev_config;
  ifs_wake_type    wake_event;
  ifs_fail_in_type fail_in;
  logic            intn_in, intn_out, intn_oe, fo_in, fo_out, fo_oe, strap;
  logic            failsafe_request, watchdog_fail_flag_request;
  int              err_count, check_count, n, p;

  ifs_top #(.PULSE_CYCLES(PW), .GAP_CYCLES(GW), .FAIL_BITS(8)) dut (
    .pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .mode, .dev_config, .wake_event,
    .wake_level(4'h5), .fail_event, .fail_in, .intn_in, .intn_out,
    .intn_oe, .fo_in, .fo_out, .fo_oe, .failsafe_request, .watchdog_fail_flag_request);
  ifs_host_model host (.intn_out, .intn_oe, .fo_out, .fo_oe, .strap,
    .intn_pin(intn_in), .fo_pin(fo_in));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task complete_run;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    n = int'(pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask

  task cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task set_mode(input ifs_mode_type m);
    @(posedge pclk);
    mode <= m;
  endtask

  task kick(input logic [3:0] w, input logic [7:0] f, input logic [1:0] wd);
    @(posedge pclk);
    wake_event <= ifs_wake_type'(w);
    fail_event <= f;
    {fail_in.wd_trigger_fail, fail_in.wd_trigger_ok} <= wd;
    @(posedge pclk);
    wake_event <= '0;
    fail_event <= 8'h00;
    {fail_in.wd_trigger_fail, fail_in.wd_trigger_ok} <= 2'h0;
  endtask

  task flt(input logic [2:0] c);
    @(posedge pclk);
    {fail_in.thermal_shutdown_level2, fail_in.supply_short,
     fail_in.supply_overvoltage} <= c;
  endtask

  // Sampled on the falling edge so the count never races the update
  task pl;
    n = 0;
    repeat (PW + GW + 10)
    begin
      @(negedge pclk);
      if (intn_out === 1'b0)
        break;
    end
    while (intn_out === 1'b0 && n < 100)
    begin
      n++;
      @(negedge pclk);
    end
  endtask

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, fail_event} = '0;
    {wake_event, fail_in, dev_config} = '0;
    {err_count, check_count} = '0;
    strap = 1'b1;
    mode = IFS_MODE_INIT;
    presetn = 1'b0;
    cyc(12);
    presetn <= 1'b1;
    cyc(2);
    chk(fo_oe, 0);
    rd(IFS_CTRL_OFS, 32'h0);
    rd(IFS_DEVICE_STATUS_OFS, 32'hc);
    rd(IFS_WAKE_LVL_OFS, 32'h5);
    set_mode(IFS_MODE_NORMAL);
    wr(IFS_CTRL_OFS, 32'h100);
    kick(4'h8, 8'h00, 2'h0);
    pl();
    chk(n, PW);
    kick(4'h8, 8'h00, 2'h0);
    kick(4'h8, 8'h00, 2'h0);
    pl();
    chk(n, PW);
    pl();
    chk(n, 0);
    rd(IFS_WAKE_A_OFS, 32'h1);
    wr(IFS_WAKE_A_OFS, 32'h1);
    rd(IFS_WAKE_A_OFS, 32'h0);
    kick(4'h4, 8'h00, 2'h0);
    pl();
    chk(n, 0);
    rd(IFS_WAKE_A_OFS, 32'h2);
    wr(IFS_WAKE_A_OFS, 32'h7);
    kick(4'h0, 8'h01, 2'h0);
    pl();
    chk(n, 0);
    rd(IFS_FAIL_STAT_OFS, 32'h1);
    wr(IFS_FAIL_STAT_OFS, 32'hff);
    wr(IFS_CTRL_OFS, 32'h101);
    kick(4'h0, 8'h80, 2'h0);
    pl();
    chk(n, PW);
    wr(IFS_FAIL_STAT_OFS, 32'hff);
    $display("interrupt pulse tests done");
    set_mode(IFS_MODE_SLEEP);
    kick(4'h8, 8'h00, 2'h0);
    pl();
    chk(n, 0);
    wr(IFS_CTRL_OFS, 32'h0);
    set_mode(IFS_MODE_NORMAL);
    pl();
    chk(n, 0);
    set_mode(IFS_MODE_STOP);
    pl();
    chk(n, PW);
    chk(failsafe_request, 0);
    set_mode(IFS_MODE_NORMAL);
    wr(IFS_WAKE_A_OFS, 32'h7);
    $display("mode interrupt tests done");
    for (p = 0; p < 2; p++)
    begin
      flt(p == 0 ? 3'h4 : 3'h2);
      cyc(4);
      chk(fo_oe, 1);
      chk(failsafe_request, 1);
      rd(IFS_DEVICE_STATUS_OFS, 32'h5);
      set_mode(IFS_MODE_STOP);
      cyc(3);
      chk(fo_oe, 1);
      set_mode(IFS_MODE_NORMAL);
      flt(3'h0);
      cyc(4);
      chk(fo_oe, 1);
      wr(IFS_DEVICE_STATUS_OFS, 32'h1);
      cyc(3);
      chk(fo_oe, 0);
    end
    flt(3'h1);
    cyc(4);
    chk(fo_oe, 0);
    wr(IFS_CTRL_OFS, 32'h4);
    cyc(3);
    chk(fo_oe, 1);
    flt(3'h0);
    wr(IFS_DEVICE_STATUS_OFS, 32'h1);
    cyc(3);
    chk(fo_oe, 0);
    $display("fail cause tests done");
    wr(IFS_CTRL_OFS, 32'h1);
    dev_config <= 2'h2;
    kick(4'h0, 8'h00, 2'h2);
    cyc(3);
    chk(fo_oe, 0);
    kick(4'h0, 8'h00, 2'h2);
    cyc(3);
    chk(fo_oe, 1);
    pl();
    chk(n, 0);
    rd(IFS_DEVICE_STATUS_OFS, 32'h7);
    wr(IFS_DEVICE_STATUS_OFS, 32'h1);
    cyc(3);
    chk(fo_oe, 1);
    kick(4'h0, 8'h00, 2'h1);
    cyc(3);
    chk(fo_oe, 0);
    dev_config <= 2'h0;
    kick(4'h0, 8'h00, 2'h2);
    cyc(3);
    chk(fo_oe, 1);
    set_mode(IFS_MODE_SLEEP);
    set_mode(IFS_MODE_NORMAL);
    wr(IFS_DEVICE_STATUS_OFS, 32'h1);
    cyc(3);
    chk(fo_oe, 0);
    kick(4'h0, 8'h00, 2'h2);
    set_mode(IFS_MODE_STOP);
    fail_in.wd_disabled <= 1'b1;
    set_mode(IFS_MODE_NORMAL);
    fail_in.wd_disabled <= 1'b0;
    wr(IFS_DEVICE_STATUS_OFS, 32'h1);
    cyc(3);
    chk(fo_oe, 0);
    $display("watchdog tests done");
    wr(IFS_CTRL_OFS, 32'h2);
    cyc(2);
    chk(fo_oe, 1);
    wr(IFS_CTRL_OFS, 32'h0);
    cyc(2);
    chk(fo_oe, 0);
    wr(IFS_CTRL_OFS, 32'h2);
    set_mode(IFS_MODE_RESTART);
    cyc(3);
    chk(fo_oe, 0);
    set_mode(IFS_MODE_NORMAL);
    rd(IFS_CTRL_OFS, 32'h0);
    for (p = 0; p < 8; p++)
    begin
      wr(IFS_CTRL_OFS, 32'(p * 16 + 2));
      cyc(2);
      chk(fo_oe, p <= 2);
      rd(IFS_CTRL_OFS, 32'(p * 16 + 2));
    end
    xfer(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    chk(n, 1);
    $display("test bit and bus tests done");
    complete_run();
  end

  initial
  begin
    cyc(20000);
    err_count++;
    complete_run();
  end
endmodule

bind ifs_top ifs_asserts #(.PULSE_CYCLES(PULSE_CYCLES),
  .GAP_CYCLES(GAP_CYCLES)) u_chk (.pclk, .presetn, .mode, .fail_in,
  .intn_out, .intn_oe, .fo_out, .fo_oe, .failsafe_request, .watchdog_fail_flag_request);
`default_nettype wire
